/* rtl/acec_defines.svh */
// constants for the ascii command error checker
// Summary of operation
// (RULE_01) any failed check aborts command, error reply
// (RULE_02) reply is ?, address, space, text
// (RULE_03) eight error texts, distinct first letters
// (RULE_04) six forbidden address codes give address error
// (RULE_05) address above 7f gives address error
// (RULE_06) two trailing hex characters are a checksum
// (RULE_07) checksum is low byte of character sum
// (RULE_08) unknown or lower-case code gives command error
// (RULE_09) commands during calibration give not-ready error
// (RULE_10) power-up, restart command, watchdog start calibration
// (RULE_11) parity error only when parity checking enabled
// (RULE_12) wrong structure or length gives syntax error
// (RULE_13) bad operand character gives value error; code: lower-case a-f only, other non-hex give syntax error
// (RULE_14) protected commands need unlock command right before
// (RULE_15) unlock cleared by success, kept over errors
// (RULE_16) setup operand exactly eight hex characters
// (RULE_17) bytes high nibble first, byte 1 first
// (RULE_18) host aborts setup with non-hex character
// (RULE_19) new address answered at once, old dropped
// (RULE_20) host should use printable addresses only
`ifndef ACEC_DEFINES_SVH
`define ACEC_DEFINES_SVH
// ****************************************
// characters
// ****************************************
`define ACEC_CH_PLAIN    8'h24
`define ACEC_CH_CKSUM    8'h23
`define ACEC_CH_CR       8'h0d
`define ACEC_CH_ERR      8'h3f
`define ACEC_CH_OK       8'h2a
`define ACEC_CH_SPACE    8'h20
`define ACEC_CH_NUL      8'h00
`define ACEC_CH_LBRACE   8'h7b
`define ACEC_CH_RBRACE   8'h7d
`define ACEC_CH_D0       8'h30
`define ACEC_CH_D9       8'h39
`define ACEC_CH_UA       8'h41
`define ACEC_CH_UF       8'h46
`define ACEC_CH_UZ       8'h5a
`define ACEC_CH_LA       8'h61
`define ACEC_CH_LF       8'h66
`define ACEC_HEX_LETTER  8'h37
`define ACEC_HEX_DIGIT   8'h30
// ****************************************
// command codes
// ****************************************
`define ACEC_CMD_UNLOCK  16'h5745
`define ACEC_CMD_WR_CFG  16'h5355
`define ACEC_CMD_RD_CFG  16'h5253
`define ACEC_CMD_RESTART 16'h5252
// ****************************************
// lengths and positions
// ****************************************
`define ACEC_CODE_LEN    4'h2
`define ACEC_SETUP_HEX   4'h8
`define ACEC_CKSUM_LEN   4'h2
`define ACEC_OP_POS      2
`define ACEC_ADDR_MSB    31
`define ACEC_ADDR_LSB    24
`define ACEC_PAR_EN_BIT  21
`define ACEC_DEFAULT_SETUP 32'h31070182
`define ACEC_TEXT_CHARS  15
// ****************************************
// timing
// ****************************************
`define ACEC_CAL_TIME_MS 2500
`define ACEC_CLK_KHZ     125000
`endif

/* rtl/acec_pkg.sv */
// types for the ascii command error checker
package acec_pkg;
  // reply kinds: success and the eight error texts
  typedef enum logic [3:0] {
    ACEC_R_OK, ACEC_R_ADDR, ACEC_R_CKSUM, ACEC_R_CMD, ACEC_R_NREADY,
    ACEC_R_PARITY, ACEC_R_SYNTAX, ACEC_R_VALUE, ACEC_R_WPROT
  } acec_reply_t;
endpackage

/* rtl/acec_reply_if.sv */
// link between command parser and reply sender
`timescale 1ns/1ns
interface acec_reply_if;
  logic                 start; // one-cycle request to send a reply
  acec_pkg::acec_reply_t code; // reply kind
  logic [7:0]           addr;  // own address character
  logic                 busy;  // reply in progress
  modport main  (output start, code, addr, input busy);
  modport reply (input start, code, addr, output busy);
endinterface

/* rtl/acec_calib.sv */
// self-calibration interval timer
`timescale 1ns/1ns
`include "acec_defines.svh"
module acec_calib #(
  parameter int unsigned CAL_CYCLES = `ACEC_CAL_TIME_MS * `ACEC_CLK_KHZ
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      ready
);
  localparam int CW = $clog2(CAL_CYCLES + 1);
  logic [CW-1:0] cnt_reg;   // cycles spent calibrating
  logic [CW-1:0] cnt_next;
  logic          busy_reg;  // calibration running
  logic          busy_next;
  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    cnt_next  = cnt_reg;
    busy_next = busy_reg;
    if (start) begin // any reset source restarts the interval
      cnt_next  = '0;
      busy_next = 1'b1;
    end else if (busy_reg) begin
      if (cnt_reg == CW'(CAL_CYCLES - 1)) begin
        busy_next = 1'b0;
      end else begin
        cnt_next = cnt_reg + CW'(1);
      end
    end
  end
  // registers; power-up starts calibrating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b1; // RULE_10
    end else begin
      cnt_reg  <= cnt_next;
      busy_reg <= busy_next;
    end
  end
  assign ready = !busy_reg;
  // ****************************************
  // checks
  // ****************************************
  restart_busy_a: assert property (@(posedge clk) disable iff (!rst_n) start |=> !ready) // RULE_10
    else $error("calibration not restarted");
  cal_done_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(ready));
endmodule

/* rtl/acec_reply.sv */
// reply sender: prompt, then for errors address, space and error text, then carriage return
`timescale 1ns/1ns
`include "acec_defines.svh"
module acec_reply (
  input  wire logic  clk,
  input  wire logic  rst_n,
  acec_reply_if.reply rif,
  input  wire logic  tx_ready,
  output logic       tx_valid,
  output logic [7:0] tx_char
);
  typedef enum logic [2:0] {S_IDLE, S_LEAD, S_ADDR, S_SPACE, S_TEXT, S_END} acec_rstate_t;
  acec_rstate_t          state_reg, state_next; // sender state
  acec_pkg::acec_reply_t code_reg, code_next;   // latched reply kind
  logic [7:0]            addr_reg, addr_next;   // latched address
  logic [3:0]            idx_reg, idx_next;     // text position
  logic [7:0]            char_reg, char_next;   // character on offer
  // right-justified texts, each first letter distinct
  function automatic logic [119:0] msg_word(acec_pkg::acec_reply_t c);
    case (c) // RULE_03
      acec_pkg::ACEC_R_ADDR:   msg_word = "ADDRESS ERROR";
      acec_pkg::ACEC_R_CKSUM:  msg_word = "BAD CHECKSUM";
      acec_pkg::ACEC_R_CMD:    msg_word = "COMMAND ERROR";
      acec_pkg::ACEC_R_NREADY: msg_word = "NOT READY";
      acec_pkg::ACEC_R_PARITY: msg_word = "PARITY ERROR";
      acec_pkg::ACEC_R_SYNTAX: msg_word = "SYNTAX ERROR";
      acec_pkg::ACEC_R_VALUE:  msg_word = "VALUE ERROR";
      acec_pkg::ACEC_R_WPROT:  msg_word = "WRITE PROTECTED";
      default:                 msg_word = '0;
    endcase
  endfunction
  // text character at a position, zero for leading pad
  function automatic logic [7:0] msg_char(acec_pkg::acec_reply_t c, logic [3:0] i);
    logic [119:0] w;
    w = msg_word(c);
    msg_char = w[8*(`ACEC_TEXT_CHARS - 1 - int'(i)) +: 8];
  endfunction
  // pad characters are skipped without a handshake
  assign tx_valid = (state_reg != S_IDLE) && (char_reg != `ACEC_CH_NUL);
  assign tx_char  = char_reg;
  assign rif.busy = (state_reg != S_IDLE);
  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    state_next = state_reg;
    code_next  = code_reg;
    addr_next  = addr_reg;
    idx_next   = idx_reg;
    char_next  = char_reg;
    if (state_reg == S_IDLE || tx_ready || char_reg == `ACEC_CH_NUL) begin
      case (state_reg)
        S_IDLE: if (rif.start) begin // RULE_02
          code_next  = rif.code;
          addr_next  = rif.addr;
          char_next  = (rif.code == acec_pkg::ACEC_R_OK) ? `ACEC_CH_OK : `ACEC_CH_ERR;
          state_next = S_LEAD;
        end
        S_LEAD: if (code_reg == acec_pkg::ACEC_R_OK) begin
          char_next  = `ACEC_CH_CR;
          state_next = S_END;
        end else begin
          char_next  = addr_reg;
          state_next = S_ADDR;
        end
        S_ADDR: begin
          char_next  = `ACEC_CH_SPACE;
          state_next = S_SPACE;
        end
        S_SPACE: begin
          idx_next   = 4'h0;
          char_next  = msg_char(code_reg, 4'h0);
          state_next = S_TEXT;
        end
        S_TEXT: if (idx_reg == 4'(`ACEC_TEXT_CHARS - 1)) begin
          char_next  = `ACEC_CH_CR;
          state_next = S_END;
        end else begin
          idx_next  = idx_reg + 4'h1;
          char_next = msg_char(code_reg, idx_reg + 4'h1);
        end
        S_END: begin
          char_next  = `ACEC_CH_NUL;
          state_next = S_IDLE;
        end
        default: state_next = S_IDLE;
      endcase
    end
  end
  // registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      code_reg  <= acec_pkg::ACEC_R_OK;
      addr_reg  <= 8'h00;
      idx_reg   <= 4'h0;
      char_reg  <= 8'h00;
    end else begin
      state_reg <= state_next;
      code_reg  <= code_next;
      addr_reg  <= addr_next;
      idx_reg   <= idx_next;
      char_reg  <= char_next;
    end
  end
  // ****************************************
  // checks
  // ****************************************
  err_lead_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
    (state_reg == S_LEAD && code_reg != acec_pkg::ACEC_R_OK) |-> tx_valid && tx_char == `ACEC_CH_ERR)
    else $error("error reply lacks question mark");
  addr_follow_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
    (state_reg == S_LEAD && tx_ready && code_reg != acec_pkg::ACEC_R_OK) |=> tx_char == addr_reg)
    else $error("address does not follow question mark");
  err_reply_c: cover property (@(posedge clk) disable iff (!rst_n) state_reg == S_TEXT && tx_valid);
endmodule

/* rtl/acec_top.sv */
// command checker: frames, checks and answers addressed ascii commands
`timescale 1ns/1ns
`include "acec_defines.svh"
module acec_top #(
  parameter int unsigned CAL_CYCLES    = `ACEC_CAL_TIME_MS * `ACEC_CLK_KHZ,
  parameter logic [31:0] DEFAULT_SETUP = `ACEC_DEFAULT_SETUP,
  parameter int          BUF_DEPTH     = 14
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_char,
  input  wire logic        rx_parity_bad,
  input  wire logic        watchdog_expire,
  input  wire logic        tx_ready,
  output logic             tx_valid,
  output logic [7:0]       tx_char,
  output logic [31:0]      setup_word,
  output logic             setup_write,
  output logic             restart,
  output logic             ready,
  output logic             write_unlocked
);
  localparam int LW = $clog2(BUF_DEPTH + 1);
  typedef enum logic [2:0] {M_IDLE, M_ADDR, M_BODY, M_SKIP, M_EVAL, M_REPLY} acec_mstate_t;
  // ****************************************
  // state
  // ****************************************
  acec_mstate_t          state_reg, state_next;   // framing state
  logic [7:0]            buf_reg [BUF_DEPTH];     // characters after address
  logic [7:0]            buf_next [BUF_DEPTH];
  logic [LW-1:0]         len_reg, len_next;       // characters held
  logic [7:0]            sum_reg, sum_next;       // running character sum
  logic                  ovf_reg, ovf_next;       // too many characters
  logic                  par_reg, par_next;       // parity fault seen in frame
  logic [31:0]           setup_reg, setup_next;   // stored setup word
  logic                  unlock_reg, unlock_next; // write unlock armed
  logic                  restart_reg, restart_next;
  // evaluation results
  acec_pkg::acec_reply_t err;      // reply for the framed command
  logic [15:0]           code;     // two-letter code
  logic                  is_unlock, is_wr_cfg, is_rd_cfg, is_restart;
  logic                  known;    // implemented code
  logic [LW-1:0]         plain_len;
  logic                  has_cs;   // checksum appended
  logic [7:0]            cs_sum;   // sum without checksum characters
  logic [7:0]            cs_val;   // received checksum
  logic                  op_bad, op_lc;
  logic [31:0]           op_word;  // parsed setup operand
  logic                  cal_ready;
  logic                  cal_start;
  acec_reply_if          rif ();
  // ****************************************
  // helpers
  // ****************************************
  // upper-case hexadecimal digit
  function automatic logic hex_ok(logic [7:0] c);
    hex_ok = (c >= `ACEC_CH_D0 && c <= `ACEC_CH_D9) || (c >= `ACEC_CH_UA && c <= `ACEC_CH_UF);
  endfunction
  // value of a hexadecimal digit
  function automatic logic [3:0] hex_val(logic [7:0] c);
    logic [7:0] v;
    v = (c >= `ACEC_CH_UA) ? c - `ACEC_HEX_LETTER : c - `ACEC_HEX_DIGIT;
    hex_val = v[3:0];
  endfunction
  // lower-case letter that looks like a hex digit
  function automatic logic lc_hex(logic [7:0] c);
    lc_hex = (c >= `ACEC_CH_LA && c <= `ACEC_CH_LF);
  endfunction
  // address codes that may never be stored
  function automatic logic addr_illegal(logic [7:0] a);
    addr_illegal = a[7] || a == `ACEC_CH_NUL || a == `ACEC_CH_CR || a == `ACEC_CH_PLAIN ||
                   a == `ACEC_CH_CKSUM || a == `ACEC_CH_LBRACE || a == `ACEC_CH_RBRACE;
  endfunction
  // upper-case letter
  function automatic logic upper(logic [7:0] c);
    upper = (c >= `ACEC_CH_UA && c <= `ACEC_CH_UZ);
  endfunction
  // ****************************************
  // command evaluation
  // ****************************************
  always_comb begin
    code       = {buf_reg[0], buf_reg[1]};
    is_unlock  = (code == `ACEC_CMD_UNLOCK);
    is_wr_cfg  = (code == `ACEC_CMD_WR_CFG);
    is_rd_cfg  = (code == `ACEC_CMD_RD_CFG);
    is_restart = (code == `ACEC_CMD_RESTART);
    // lower-case codes never match the table
    known      = upper(buf_reg[0]) && upper(buf_reg[1]) &&
                 (is_unlock || is_wr_cfg || is_rd_cfg || is_restart); // RULE_08
    plain_len  = LW'(`ACEC_CODE_LEN + (is_wr_cfg ? `ACEC_SETUP_HEX : 4'h0)); // RULE_16
    has_cs     = (len_reg == plain_len + LW'(`ACEC_CKSUM_LEN)); // RULE_06
    // checksum over every character before it
    cs_sum     = 8'(sum_reg - buf_reg[len_reg - LW'(1)] - buf_reg[len_reg - LW'(2)]); // RULE_07
    cs_val     = {hex_val(buf_reg[len_reg - LW'(2)]), hex_val(buf_reg[len_reg - LW'(1)])};
    op_bad     = 1'b0;
    op_lc      = 1'b0;
    op_word    = '0;
    // high nibble first, byte 1 first
    for (int i = 0; i < int'(`ACEC_SETUP_HEX); i++) begin
      op_word[`ACEC_ADDR_MSB - 4*i -: 4] = hex_val(buf_reg[`ACEC_OP_POS + i]); // RULE_17
      if (!hex_ok(buf_reg[`ACEC_OP_POS + i])) begin
        op_bad = 1'b1;
        op_lc  = op_lc | lc_hex(buf_reg[`ACEC_OP_POS + i]);
      end
    end
    // checks in priority order; first failure wins
    if (!cal_ready) begin
      err = acec_pkg::ACEC_R_NREADY; // RULE_09
    end else if (par_reg && setup_reg[`ACEC_PAR_EN_BIT]) begin
      err = acec_pkg::ACEC_R_PARITY; // RULE_11
    end else if (ovf_reg || len_reg < LW'(`ACEC_CODE_LEN)) begin
      err = acec_pkg::ACEC_R_SYNTAX; // RULE_12
    end else if (!known) begin
      err = acec_pkg::ACEC_R_CMD; // RULE_08
    end else if (len_reg != plain_len && !has_cs) begin
      err = acec_pkg::ACEC_R_SYNTAX; // RULE_12
    end else if (has_cs && !(hex_ok(buf_reg[len_reg - LW'(1)]) && hex_ok(buf_reg[len_reg - LW'(2)]))) begin
      err = acec_pkg::ACEC_R_SYNTAX; // RULE_12
    end else if (has_cs && cs_val != cs_sum) begin
      err = acec_pkg::ACEC_R_CKSUM; // RULE_06
    end else if (is_wr_cfg && op_bad) begin
      // lower-case hex is a bad value, anything else aborts the operand
      err = op_lc ? acec_pkg::ACEC_R_VALUE : acec_pkg::ACEC_R_SYNTAX; // RULE_13 RULE_16
    end else if ((is_wr_cfg || is_restart) && !unlock_reg) begin
      err = acec_pkg::ACEC_R_WPROT; // RULE_14
    end else if (is_wr_cfg && addr_illegal(op_word[`ACEC_ADDR_MSB:`ACEC_ADDR_LSB])) begin
      err = acec_pkg::ACEC_R_ADDR; // RULE_04 RULE_05
    end else begin
      err = acec_pkg::ACEC_R_OK;
    end
  end
  // ****************************************
  // framing and actions: next state
  // ****************************************
  always_comb begin
    state_next   = state_reg;
    buf_next     = buf_reg;
    len_next     = len_reg;
    sum_next     = sum_reg;
    ovf_next     = ovf_reg;
    par_next     = par_reg;
    setup_next   = setup_reg;
    unlock_next  = unlock_reg;
    restart_next = 1'b0;
    case (state_reg)
      // wait for either prompt
      M_IDLE: if (rx_valid && (rx_char == `ACEC_CH_PLAIN || rx_char == `ACEC_CH_CKSUM)) begin
        sum_next   = rx_char;
        len_next   = '0;
        ovf_next   = 1'b0;
        par_next   = rx_parity_bad;
        state_next = M_ADDR;
      end
      // only the current address is answered
      M_ADDR: if (rx_valid) begin
        par_next = par_reg | rx_parity_bad;
        if (rx_char == setup_reg[`ACEC_ADDR_MSB:`ACEC_ADDR_LSB]) begin // RULE_19
          sum_next   = sum_reg + rx_char;
          state_next = M_BODY;
        end else if (rx_char == `ACEC_CH_CR) begin
          state_next = M_IDLE;
        end else begin
          state_next = M_SKIP;
        end
      end
      // collect up to carriage return
      M_BODY: if (rx_valid) begin
        par_next = par_reg | rx_parity_bad;
        if (rx_char == `ACEC_CH_CR) begin
          state_next = M_EVAL;
        end else if (len_reg == LW'(BUF_DEPTH)) begin
          ovf_next = 1'b1; // RULE_12
        end else begin
          buf_next[len_reg] = rx_char;
          len_next          = len_reg + LW'(1);
          sum_next          = sum_reg + rx_char;
        end
      end
      // another module's frame
      M_SKIP: if (rx_valid && rx_char == `ACEC_CH_CR) begin
        state_next = M_IDLE;
      end
      // act only when every check passed
      M_EVAL: begin
        if (err == acec_pkg::ACEC_R_OK) begin // RULE_01
          unlock_next  = is_unlock; // RULE_15
          restart_next = is_restart; // RULE_10
          if (is_wr_cfg) begin
            setup_next = op_word;
          end
        end
        state_next = M_REPLY;
      end
      // hold off new frames until the reply is out
      M_REPLY: if (!rif.busy) begin
        state_next = M_IDLE;
      end
      default: state_next = M_IDLE;
    endcase
    if (cal_start) begin
      unlock_next = 1'b0;
    end
  end
  // registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= M_IDLE;
      len_reg     <= '0;
      sum_reg     <= 8'h00;
      ovf_reg     <= 1'b0;
      par_reg     <= 1'b0;
      setup_reg   <= DEFAULT_SETUP;
      unlock_reg  <= 1'b0;
      restart_reg <= 1'b0;
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_reg[i] <= 8'h00;
      end
    end else begin
      state_reg   <= state_next;
      buf_reg     <= buf_next;
      len_reg     <= len_next;
      sum_reg     <= sum_next;
      ovf_reg     <= ovf_next;
      par_reg     <= par_next;
      setup_reg   <= setup_next;
      unlock_reg  <= unlock_next;
      restart_reg <= restart_next;
    end
  end
  // ****************************************
  // reply, calibration, outputs
  // ****************************************
  // reply sender takes the verdict in the evaluation cycle
  assign rif.start = (state_reg == M_EVAL);
  assign rif.code  = err;
  assign rif.addr  = setup_reg[`ACEC_ADDR_MSB:`ACEC_ADDR_LSB]; // RULE_02
  assign cal_start = restart_reg | watchdog_expire; // RULE_10
  acec_reply u_reply (
    .clk      (clk),
    .rst_n    (rst_n),
    .rif      (rif.reply),
    .tx_ready (tx_ready),
    .tx_valid (tx_valid),
    .tx_char  (tx_char)
  );
  // calibration timer, restarted by every reset source
  acec_calib #(.CAL_CYCLES(CAL_CYCLES)) u_calib (
    .clk   (clk),
    .rst_n (rst_n),
    .start (cal_start),
    .ready (cal_ready)
  );
  assign setup_word     = setup_reg;
  assign setup_write    = (state_reg == M_EVAL) && (err == acec_pkg::ACEC_R_OK) && is_wr_cfg;
  assign restart        = restart_reg;
  assign ready          = cal_ready;
  assign write_unlocked = unlock_reg;
  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  abort_no_write_a: assert property (rif.start && err != acec_pkg::ACEC_R_OK |=> $stable(setup_reg)) // RULE_01
    else $error("failed command changed setup");
  not_ready_a: assert property (rif.start && !cal_ready |-> err == acec_pkg::ACEC_R_NREADY) // RULE_09
    else $error("busy module gave other reply");
  parity_off_a: assert property (!setup_reg[`ACEC_PAR_EN_BIT] |-> err != acec_pkg::ACEC_R_PARITY) // RULE_11
    else $error("parity error while checking off");
  legal_addr_a: assert property (setup_write |=> !addr_illegal(setup_reg[`ACEC_ADDR_MSB:`ACEC_ADDR_LSB])) // RULE_04
    else $error("illegal address stored");
  addr_msb_a: assert property (setup_write |=> setup_reg[`ACEC_ADDR_MSB] == 1'b0) // RULE_05
    else $error("address above 7f stored");
  protect_a: assert property ((setup_write || restart_next) |-> unlock_reg) // RULE_14
    else $error("protected command ran locked");
  unlock_use_a: assert property (rif.start && err == acec_pkg::ACEC_R_OK && !is_unlock |=> !unlock_reg) // RULE_15
    else $error("unlock kept after success");
  unlock_keep_a: assert property (rif.start && err != acec_pkg::ACEC_R_OK && unlock_reg && !cal_start
    |=> unlock_reg) // RULE_15
    else $error("unlock lost on error");
  restart_cal_a: assert property (restart |=> !ready) // RULE_10
    else $error("restart did not start calibration");
  new_addr_a: assert property (setup_write |=> rif.addr == $past(op_word[`ACEC_ADDR_MSB:`ACEC_ADDR_LSB])) // RULE_19
    else $error("new address not in use");
  setup_c:    cover property (setup_write);
  cksum_c:    cover property (rif.start && err == acec_pkg::ACEC_R_CKSUM);
  wprot_c:    cover property (rif.start && err == acec_pkg::ACEC_R_WPROT);
  addr_err_c: cover property (rif.start && err == acec_pkg::ACEC_R_ADDR);
  // every evaluated frame gets a reply
  reply_start_a: assert property (rif.start |=> rif.busy) // RULE_01
    else $error("no reply after evaluation");
  // parity faults are reported when checking is on and calibration is done
  parity_on_a: assert property (rif.start && cal_ready && par_reg && setup_reg[`ACEC_PAR_EN_BIT] // RULE_11
    |-> err == acec_pkg::ACEC_R_PARITY)
    else $error("parity fault not reported");
  // an accepted setup write leaves the parsed word in place
  setup_load_a: assert property (setup_write |=> setup_word == $past(op_word)) // RULE_17
    else $error("setup word not loaded");
  // the restart pulse only follows an evaluated frame while unlock was armed
  restart_src_a: assert property (restart |-> $past(rif.start) && $past(unlock_reg)) // RULE_14
    else $error("restart without unlocked command");
endmodule

/* testbench/acec_host.sv */
// host model: takes reply characters with stalls
`timescale 1ns/1ns
module acec_host (
  input  wire logic       clk,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_char,
  output logic            tx_ready
);
  logic [1:0] cnt_reg = 2'h0; // stall pattern
  string      rply;           // reply text without the cr
  bit         done;           // final cr seen
  initial tx_ready = 1'b0;
  // ready three cycles in four, so the sender sees stalls
  always @(posedge clk) begin
    cnt_reg  <= cnt_reg + 2'h1;
    tx_ready <= cnt_reg != 2'h0;
    if (tx_valid && tx_ready && tx_char == 8'h0d) done = 1'b1;
    else if (tx_valid && tx_ready) rply = {rply, string'(tx_char)};
  end
endmodule

/* testbench/tb.sv */
// bench for the command checker
`timescale 1ns/1ns
module tb;
  logic        clk = 1'b0, rst_n = 1'b0, rx_valid = 1'b0, rx_parity_bad = 1'b0, watchdog_expire = 1'b0;
  logic [7:0]  rx_char = 8'h00, tx_char;
  logic        tx_ready, tx_valid, setup_write, restart, ready, write_unlocked;
  logic [31:0] setup_word;
  int          failures = 0, comparisons = 0;
  int          n_wr = 0, n_rst = 0; // action pulses seen
  always #4 clk = ~clk;
  // count one-cycle action pulses
  always @(posedge clk) begin
    if (setup_write === 1'b1) n_wr++;
    if (restart === 1'b1) n_rst++;
  end
  acec_top #(.CAL_CYCLES(50)) i_dut (.clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_char(rx_char),
    .rx_parity_bad(rx_parity_bad), .watchdog_expire(watchdog_expire), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_char(tx_char), .setup_word(setup_word), .setup_write(setup_write),
    .restart(restart), .ready(ready), .write_unlocked(write_unlocked));
  acec_host i_host (.clk(clk), .tx_valid(tx_valid), .tx_char(tx_char), .tx_ready(tx_ready));
  task end_sim();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk_s(string n, string e, string g);
    comparisons++;
    if (e != g) begin
      failures++;
      $display("CHECK FAILED %s exp %s got %s", n, e, g);
    end
  endtask
  task chk_v(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (e !== g) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // low byte of the character sum, two upper-case hex digits
  function automatic string ck(string s);
    logic [7:0] a = 8'h00;
    foreach (s[i]) a += s[i];
    return $sformatf("%02X", a);
  endfunction
  // send a frame back to back, then judge the whole reply
  task cx(string s, string e, bit p = 1'b0);
    int i;
    for (i = 0; i <= s.len(); i++) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_char <= (i < s.len()) ? s[i] : 8'h0d;
      rx_parity_bad <= p;
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    for (i = 0; i < 3000 && !i_host.done; i++) @(posedge clk);
    chk_s(s, e, i_host.rply);
    if (!i_host.done) begin
      failures++;
      end_sim();
    end
    i_host.done = 1'b0;
    i_host.rply = "";
    repeat (2) @(posedge clk);
  endtask
  task wait_rdy();
    int i;
    for (i = 0; i < 200 && ready !== 1'b1; i++) @(posedge clk);
    chk_v("ready", 1, ready);
    if (ready !== 1'b1) end_sim();
  endtask
  task t_calib();
    cx("$1RS", "?1 NOT READY");
    wait_rdy();
  endtask
  task t_cmd();
    cx("$1rs", "?1 COMMAND ERROR");
    cx({"#1rs", ck("#1rs")}, "?1 COMMAND ERROR");
    cx("$1RS", "*", 1'b1);
    cx("$1RSX", "?1 SYNTAX ERROR");
  endtask
  task t_prot();
    cx("$1SU32070182", "?1 WRITE PROTECTED");
    cx("$1WE", "*");
    cx("$1SU7D070182", "?1 ADDRESS ERROR");
    cx("$1SU81070182", "?1 ADDRESS ERROR");
    cx("$1SU3107018a", "?1 VALUE ERROR");
    cx("$1SU31X", "?1 SYNTAX ERROR");
    cx("#1SU3207018200", "?1 BAD CHECKSUM");
    chk_v("unlock", 1, write_unlocked);
    cx({"#1SU32070182", ck("#1SU32070182")}, "*");
    chk_v("setup", 32'h32070182, setup_word);
    chk_v("setup_write", 1, n_wr);
    chk_v("unlock", 0, write_unlocked);
    cx("$2rs", "?2 COMMAND ERROR");
    cx("$2WE", "*");
    cx("$2SU32270182", "*");
    cx("$2RS", "?2 PARITY ERROR", 1'b1);
    chk_v("setup_write", 2, n_wr);
  endtask
  task t_wdog();
    @(posedge clk) watchdog_expire <= 1'b1;
    @(posedge clk) watchdog_expire <= 1'b0;
    cx("$2RS", "?2 NOT READY");
    wait_rdy();
    cx("$2WE", "*");
    cx("$2RR", "*");
    chk_v("restart", 1, n_rst);
    cx("$2RS", "?2 NOT READY");
    wait_rdy();
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_calib();
    t_cmd();
    t_prot();
    t_wdog();
    end_sim();
  end
endmodule
